/* src/acs_defines.svh */
// Register offsets, field positions, reset values and functional notes of the converter channel block
// Functional notes
// R1: Condition field selects complete, below, above
// R2: Priority field enables and ranks request
// R3: Request raised while flag set, enabled
// R4: Flag set on completion in complete mode
// R5: Compare modes set flag on condition
// R6: Vector execution clears the flag
// R7: Writing one clears flag, zero keeps
// R8: Signed results in two's complement
// R9: Result split into low, high bytes
// R10: Left adjusted: bits 11:4 high, 3:0 low
// R11: Right adjusted: 11:8 high low nibble
// R12: Right adjusted high nibble sign or zero
// R13: Eight-bit high byte sign or zero
// R14: Low byte holds eight low bits
// R15: Nonzero scan count enables scanning
// R16: Positive input is base plus position
// R17: Position steps, wraps after reaching count
// R18: Scan covers count plus one inputs
// R19: Scan position applies to channel 0
// R20: Software writes zero to reserved bits
// R21: Compare against 16-bit threshold pair
// R22: Four-bit base positive input selection
// R23: Writing scan count restarts position
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define ACS_OFF_MUX       4'h1
`define ACS_OFF_IRQ_CTRL  4'h2
`define ACS_OFF_IRQ_FLAGS 4'h3
`define ACS_OFF_VAL_LOW   4'h4
`define ACS_OFF_VAL_HIGH  4'h5
`define ACS_OFF_SCAN      4'h6
`define ACS_OFF_CMP_LOW   4'h8
`define ACS_OFF_CMP_HIGH  4'h9
`define ACS_OFF_MODE      4'ha

// ****************************************
// Field positions and reset values
// ****************************************
`define ACS_IRQ_COND_MSB  3
`define ACS_IRQ_COND_LSB  2
`define ACS_IRQ_PRIO_MSB  1
`define ACS_IRQ_PRIO_LSB  0
`define ACS_FLAG_BIT      0
`define ACS_POSITIVE_INPUT_SELECT_MSB    6
`define ACS_POSITIVE_INPUT_SELECT_LSB    3
`define ACS_SCAN_POS_MSB  7
`define ACS_SCAN_POS_LSB  4
`define ACS_SCAN_CNT_MSB  3
`define ACS_SCAN_CNT_LSB  0
`define ACS_RST_BYTE      8'h00
`define ACS_RST_WORD      16'h0000

`endif

/* src/acs_pkg.sv */
// Types of the converter channel block
package acs_pkg;

  // Interrupt condition encodings
  typedef enum logic [1:0] {
    ACS_COND_COMPLETE = 2'h0,
    ACS_COND_BELOW    = 2'h1,
    ACS_COND_RSVD     = 2'h2,
    ACS_COND_ABOVE    = 2'h3
  } acs_cond_t;

  // Result formats
  typedef enum logic [1:0] {
    ACS_FMT_RIGHT12 = 2'h0,
    ACS_FMT_LEFT12  = 2'h1,
    ACS_FMT_BIT8    = 2'h2,
    ACS_FMT_RSVD    = 2'h3
  } acs_fmt_t;

endpackage : acs_pkg

/* src/acs_channel.sv */
// Converter channel: interrupt condition, flag, result formatting and input scan
`timescale 1ns/1ps
`include "acs_defines.svh"

module acs_channel (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        conv_done,
  input  wire logic [11:0] converted_word,
  input  wire logic        conv_first_channel,
  input  wire logic        irq_vector_ack,
  output logic      [1:0]  irq_request_level,
  output logic      [3:0]  conv_positive_select
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  irq_ctrl_q;
  logic        flag_q;
  logic [6:3]  mux_q;
  logic [3:0]  scan_pos_q;
  logic [3:0]  scan_cnt_q;
  logic [15:0] cmp_q;
  logic [3:0]  mode_q;
  logic [15:0] value_q;

  acs_pkg::acs_cond_t irq_condition_select;
  acs_pkg::acs_fmt_t  fmt;
  logic [1:0]         irq_priority_level;
  logic               signed_mode;
  logic               diff_mode;
  logic               scan_on;
  logic [15:0]        value_d;
  logic               cond_hit;
  logic               wr_flags;
  logic               wr_scan;
  logic [7:0]         irq_ctrl_d;
  logic               flag_d;
  logic               flag_set;
  logic               flag_clr;
  logic [3:0]         mux_d;
  logic [15:0]        cmp_d;
  logic [3:0]         mode_d;
  logic [3:0]         scan_cnt_d;
  logic [3:0]         scan_pos_d;
  logic               scan_step;
  logic [7:0]         reg_rdata_d;

  // Address decode used by the write paths; the read path decodes in its own case
  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  assign irq_condition_select = acs_pkg::acs_cond_t'(irq_ctrl_q[`ACS_IRQ_COND_MSB:`ACS_IRQ_COND_LSB]); // R1
  assign irq_priority_level   = irq_ctrl_d[`ACS_IRQ_PRIO_MSB:`ACS_IRQ_PRIO_LSB]; // R2
  assign fmt                  = acs_pkg::acs_fmt_t'(mode_q[1:0]);
  assign signed_mode          = mode_q[2];
  assign diff_mode            = mode_q[3];
  assign scan_on              = (scan_cnt_q != 4'h0); // R15
  assign wr_flags             = reg_wr && reg_hit(reg_addr, `ACS_OFF_IRQ_FLAGS);
  assign wr_scan              = reg_wr && reg_hit(reg_addr, `ACS_OFF_SCAN);

  // Signed compare when in signed mode, else unsigned
  function automatic logic is_below(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    if (sgn) begin
      is_below = $signed(a) < $signed(b);
    end else begin
      is_below = a < b;
    end
  endfunction : is_below

  // ****************************************
  // Result formatting
  // ****************************************
  // Builds the 16-bit value from the raw conversion word
  always_comb begin
    value_d = `ACS_RST_WORD; // R9
    case (fmt)
      acs_pkg::ACS_FMT_LEFT12: begin
        value_d = {converted_word, 4'h0}; // R10
      end
      acs_pkg::ACS_FMT_BIT8: begin
        value_d = {{8{signed_mode & converted_word[7]}}, converted_word[7:0]}; // R13 R14 R8
      end
      acs_pkg::ACS_FMT_RIGHT12: begin
        value_d = {{4{diff_mode & converted_word[11]}}, converted_word}; // R11 R12 R14 R8
      end
      default: begin
        value_d = {4'h0, converted_word};
      end
    endcase
  end

  // Evaluates the selected condition on the fresh result
  always_comb begin
    case (irq_condition_select)
      acs_pkg::ACS_COND_COMPLETE: cond_hit = 1'b1; // R4
      acs_pkg::ACS_COND_BELOW:    cond_hit = is_below(value_d, cmp_q, signed_mode); // R5 R21
      acs_pkg::ACS_COND_ABOVE:    cond_hit = is_below(cmp_q, value_d, signed_mode); // R5 R21
      default:                    cond_hit = 1'b0;
    endcase
  end

  // Result capture
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      value_q <= `ACS_RST_WORD;
    end else if (conv_done) begin
      value_q <= value_d;
    end
  end

  // ****************************************
  // Flag and request
  // ****************************************
  // Set and clear sources of this cycle
  assign flag_set = conv_done && cond_hit; // R4 R5
  assign flag_clr = irq_vector_ack || (wr_flags && reg_wdata[`ACS_FLAG_BIT]); // R6 R7

  // Next flag value; a set in the same cycle as a clear wins,
  // so an event that lands beside a clear is never lost
  always_comb begin
    flag_d = flag_q;
    if (flag_set) begin
      flag_d = 1'b1; // R4 R5
    end else if (flag_clr) begin
      flag_d = 1'b0; // R6 R7
    end
  end

  // Event flag register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ****************************************
  // Request
  // ****************************************
  // Request follows the next flag and the next priority field, so a
  // priority write or a clear shows on the request in the same cycle
  // as on the registers; a zero priority keeps the request quiet
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_request_level <= 2'h0;
    end else if (flag_d) begin
      irq_request_level <= irq_priority_level; // R3 R2
    end else begin
      irq_request_level <= 2'h0;
    end
  end

  // ****************************************
  // Interrupt control
  // ****************************************
  // Next control value; reserved upper bits are held at zero
  always_comb begin
    irq_ctrl_d = irq_ctrl_q;
    if (reg_wr && reg_hit(reg_addr, `ACS_OFF_IRQ_CTRL)) begin
      irq_ctrl_d = {4'h0, reg_wdata[3:0]}; // R1 R2
    end
  end

  // Control register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_ctrl_q <= `ACS_RST_BYTE;
    end else begin
      irq_ctrl_q <= irq_ctrl_d;
    end
  end

  // ****************************************
  // Base positive selection
  // ****************************************
  // Next base selection; the negative input field is not kept here
  always_comb begin
    mux_d = mux_q;
    if (reg_wr && reg_hit(reg_addr, `ACS_OFF_MUX)) begin
      mux_d = reg_wdata[`ACS_POSITIVE_INPUT_SELECT_MSB:`ACS_POSITIVE_INPUT_SELECT_LSB]; // R22
    end
  end

  // Base selection register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mux_q <= 4'h0;
    end else begin
      mux_q <= mux_d;
    end
  end

  // ****************************************
  // Compare threshold
  // ****************************************
  // Next threshold, written one byte at a time; there is no staging
  // register, so software sees a half-written value between the writes
  always_comb begin
    cmp_d = cmp_q;
    if (reg_wr && reg_hit(reg_addr, `ACS_OFF_CMP_LOW)) begin
      cmp_d[7:0] = reg_wdata; // R21
    end
    if (reg_wr && reg_hit(reg_addr, `ACS_OFF_CMP_HIGH)) begin
      cmp_d[15:8] = reg_wdata; // R21
    end
  end

  // Threshold register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_q <= `ACS_RST_WORD;
    end else begin
      cmp_q <= cmp_d;
    end
  end

  // ****************************************
  // Result mode
  // ****************************************
  // Next format, signed and differential bits
  always_comb begin
    mode_d = mode_q;
    if (reg_wr && reg_hit(reg_addr, `ACS_OFF_MODE)) begin
      mode_d = reg_wdata[3:0];
    end
  end

  // Mode register; a conversion in the write cycle uses the old mode
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= 4'h0;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ****************************************
  // Input scan
  // ****************************************
  // Only conversions on the first channel move the scan
  assign scan_step = conv_done && conv_first_channel && scan_on; // R19

  // Next scan count
  always_comb begin
    scan_cnt_d = scan_cnt_q;
    if (wr_scan) begin
      scan_cnt_d = reg_wdata[`ACS_SCAN_CNT_MSB:`ACS_SCAN_CNT_LSB]; // R15
    end
  end

  // Scan count register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scan_cnt_q <= 4'h0;
    end else begin
      scan_cnt_q <= scan_cnt_d;
    end
  end

  // Next position; a count write restarts the scan at the base,
  // otherwise the position steps and wraps after reaching the count
  always_comb begin
    scan_pos_d = scan_pos_q;
    if (wr_scan) begin
      scan_pos_d = 4'h0; // R23
    end else if (scan_step) begin
      if (scan_pos_q == scan_cnt_q) begin
        scan_pos_d = 4'h0; // R17 R18
      end else begin
        scan_pos_d = scan_pos_q + 4'h1; // R17
      end
    end
  end

  // Scan position register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scan_pos_q <= 4'h0;
    end else begin
      scan_pos_q <= scan_pos_d;
    end
  end

  // ****************************************
  // Positive input selection
  // ****************************************
  // Built from the values about to stand, so the pin follows a base or
  // scan write in the same cycle; the sum wraps in four bits
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conv_positive_select <= 4'h0;
    end else if (scan_cnt_d != 4'h0) begin
      conv_positive_select <= mux_d + scan_pos_d; // R15 R16
    end else begin
      conv_positive_select <= mux_d;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Addressed register contents; unmapped offsets read zero
  always_comb begin
    reg_rdata_d = `ACS_RST_BYTE;
    case (reg_addr)
      `ACS_OFF_MUX:       reg_rdata_d = {1'b0, mux_q, 3'h0};
      `ACS_OFF_IRQ_CTRL:  reg_rdata_d = irq_ctrl_q;
      `ACS_OFF_IRQ_FLAGS: reg_rdata_d = {7'h00, flag_q};
      `ACS_OFF_VAL_LOW:   reg_rdata_d = value_q[7:0]; // R9
      `ACS_OFF_VAL_HIGH:  reg_rdata_d = value_q[15:8]; // R9
      `ACS_OFF_SCAN:      reg_rdata_d = {scan_pos_q, scan_cnt_q};
      `ACS_OFF_CMP_LOW:   reg_rdata_d = cmp_q[7:0];
      `ACS_OFF_CMP_HIGH:  reg_rdata_d = cmp_q[15:8];
      `ACS_OFF_MODE:      reg_rdata_d = {4'h0, mode_q};
      default:            reg_rdata_d = `ACS_RST_BYTE;
    endcase
  end

  // Read data stands for the one cycle after the strobe and is zero
  // otherwise, so the bus can OR several slaves without a select
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `ACS_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= reg_rdata_d;
    end else begin
      reg_rdata <= `ACS_RST_BYTE;
    end
  end

endmodule : acs_channel

/* dv/acs_channel_properties.sv */
// Port checker for the converter channel
`timescale 1ns/1ps
module acs_channel_chk (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        conv_done,
  input wire logic [11:0] converted_word,
  input wire logic        conv_first_channel,
  input wire logic        irq_vector_ack,
  input wire logic [1:0]  irq_request_level,
  input wire logic [3:0]  conv_positive_select
);
  // ****************
  // Port relations
  // ****************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  ctrl_rsvd_a: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata[7:4] == 4'h0)
    else $error("control reserved bits set");
  flag_rsvd_a: assert property (reg_rd && reg_addr == 4'h3 |=> reg_rdata[7:1] == 7'h00)
    else $error("flag reserved bits set");
  flag_w1c_a: assert property (reg_wr && reg_addr == 4'h3 && reg_wdata[0] && !conv_done
    |=> irq_request_level == 2'h0) else $error("flag not cleared by write");
  vector_clear_a: assert property (irq_vector_ack && !conv_done |=> irq_request_level == 2'h0)
    else $error("flag not cleared by vector");
  irq_quiet_a: assert property (irq_request_level == 2'h0 && !conv_done && !reg_wr
    |=> irq_request_level == 2'h0) else $error("request without event");
  select_hold_a: assert property (!conv_done && !reg_wr |=> $stable(conv_positive_select))
    else $error("select moved without conversion");
  other_chan_a: assert property (conv_done && !conv_first_channel && !reg_wr
    |=> $stable(conv_positive_select)) else $error("scan stepped off channel");
endmodule : acs_channel_chk

/* dv/acs_channel_tb.sv */
// Self-checking bench for the converter channel
`timescale 1ns/1ps
module acs_channel_tb;
  logic        core_clk, resetn, reg_wr, reg_rd, conv_done, conv_first_channel, irq_vector_ack;
  logic [3:0]  reg_addr, conv_positive_select;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [11:0] converted_word;
  logic [1:0]  irq_request_level;
  int          n_mismatch, checked;

  acs_channel dut_u (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .conv_done, .converted_word, .conv_first_channel, .irq_vector_ack, .irq_request_level,
    .conv_positive_select);

  // ****************
  // Drivers
  // ****************
  // Clock at 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data is judged in the single cycle it stands
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(16'(reg_rdata), 16'(e));
  endtask : rd

  task automatic conv(input logic [11:0] w, input logic f);
    @(posedge core_clk);
    conv_done          <= 1'b1;
    converted_word     <= w;
    conv_first_channel <= f;
    @(posedge core_clk);
    conv_done <= 1'b0;
    #1;
  endtask : conv

  task automatic t_format();
    logic [35:0] t [5] = '{36'h00a5c5c0a, 36'h08a5c5cfa, 36'h01a5cc0a5, 36'h060a5a5ff, 36'h020a5a500};
    foreach (t[i]) begin
      wr(4'ha, t[i][35:28]);
      conv(t[i][27:16], 1'b0);
      rd(4'h4, t[i][15:8]);
      rd(4'h5, t[i][7:0]);
    end
  endtask : t_format

  task automatic t_irq();
    wr(4'h2, 8'h02);
    rd(4'h2, 8'h02);
    conv(12'h123, 1'b0);
    check(16'(irq_request_level), 16'h2);
    rd(4'h3, 8'h01);
    wr(4'h3, 8'h00);
    check(16'(irq_request_level), 16'h2);
    wr(4'h3, 8'h01);
    check(16'(irq_request_level), 16'h0);
    conv(12'h123, 1'b0);
    @(posedge core_clk);
    irq_vector_ack <= 1'b1;
    @(posedge core_clk);
    irq_vector_ack <= 1'b0;
    #1;
    check(16'(irq_request_level), 16'h0);
  endtask : t_irq

  // Mode, control, word and expected level per entry
  task automatic t_compare();
    logic [31:0] t [8] = '{32'h00050ff1, 32'h00051000, 32'h000d1011, 32'h000d1000,
      32'h00090ff0, 32'h00010001, 32'h0c0dfff0, 32'h0c05fff1};
    wr(4'h8, 8'h00);
    wr(4'h9, 8'h01);
    foreach (t[i]) begin
      wr(4'ha, t[i][31:24]);
      wr(4'h2, t[i][23:16]);
      wr(4'h3, 8'h01);
      conv(t[i][15:4], 1'b0);
      check(16'(irq_request_level), 16'(t[i][3:0]));
    end
  endtask : t_compare

  task automatic t_scan();
    wr(4'h1, 8'h18);
    conv(12'h000, 1'b1);
    check(16'(conv_positive_select), 16'h3);
    wr(4'h6, 8'h02);
    conv(12'h000, 1'b1);
    wr(4'h6, 8'h02);
    check(16'(conv_positive_select), 16'h3);
    for (int i = 0; i < 4; i++) begin
      conv(12'h000, i != 2);
      check(16'(conv_positive_select), (16'h3554 >> (4 * i)) & 16'h000f);
    end
    rd(4'h6, 8'h02);
  endtask : t_scan

  task automatic conclude();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // Main sequence after an 8-cycle reset
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    conv_done = 1'b0;
    converted_word = 12'h000;
    conv_first_channel = 1'b0;
    irq_vector_ack = 1'b0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    rd(4'h2, 8'h00);
    rd(4'h7, 8'h00);
    t_format();
    t_irq();
    t_compare();
    t_scan();
    conclude();
  end

  // Hang guard
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule : acs_channel_tb

bind acs_channel acs_channel_chk chk_u (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .conv_done, .converted_word, .conv_first_channel, .irq_vector_ack, .irq_request_level,
  .conv_positive_select);
